// ==== logic/ssw_switcher.sv ====
// Run-time protocol switcher of one serial channel
`timescale 1ns/10ps
module ssw_switcher #(
  parameter bit          IS_EXPANSION = 1'b1,
  parameter logic [0:0]  CHANNEL      = 1'h0
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Control word access and write command
  input  wire logic                ctrlWrEn,
  input  wire logic [15:0]         ctrlWrData,
  input  wire logic                writeCmd,
  output logic      [15:0]         ctrlRdData,
  // Start events and application setup
  input  wire logic                coldStart,
  input  wire logic                warmStart,
  input  wire logic                useAppCfg,
  input  wire ssw_pkg::ssw_mode_t  appMode,
  input  wire logic [15:0]         appLineParams,
  input  wire logic [7:0]          appSlaveNum,
  // Stored slave number
  input  wire logic                nvSlaveValid,
  input  wire logic [7:0]          nvSlaveNum,
  // Line engine status
  input  wire logic                lineBusy,
  input  wire logic                reqLost,
  input  wire logic                slaveAbsent,
  // Active configuration
  output ssw_pkg::ssw_mode_t       mode,
  output logic      [15:0]         lineParams,
  output logic      [15:0]         frameDelayUs,
  output logic      [15:0]         answerTimeoutMs,
  output logic      [3:0]          retryCount,
  output ssw_pkg::ssw_end_t        endDetect,
  output logic      [15:0]         silenceMs,
  output logic      [7:0]          endChar,
  output logic      [7:0]          slaveNum,
  // Command results
  output logic                     cmdDone,
  output logic                     cmdError,
  output logic                     switchPending,
  output logic      [15:0]         exchReport
);
  import ssw_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} ssw_state_t;

  localparam logic [15:0] DEF_LINE = (CHANNEL == 1'h0) ? DEF_LINE_CH0 : DEF_LINE_CH1;

  ssw_state_t  state_r, state_nxt;
  ssw_mode_t   target_r, target_nxt;
  ssw_mode_t   mode_r, mode_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] line_r, line_nxt;
  logic [15:0] fd_r, fd_nxt;
  logic [15:0] ato_r, ato_nxt;
  logic [3:0]  retry_r, retry_nxt;
  ssw_end_t    endDet_r, endDet_nxt;
  logic [15:0] sil_r, sil_nxt;
  logic [7:0]  endChar_r, endChar_nxt;
  logic [7:0]  slave_r, slave_nxt;
  logic [7:0]  initSlave_r, initSlave_nxt;
  logic        initIsSlave_r, initIsSlave_nxt;
  logic        done_r, done_nxt;
  logic        err_r, err_nxt;
  logic [15:0] report_r, report_nxt;

  logic        reqMaster, reqSlave, reqChar, reqMulti, reqNone;
  logic [15:0] defDelayUs;
  logic        startReq;
  logic        applyNow;
  logic        cmdTaken;
  ssw_mode_t   reqMode;

  ssw_req_decode uDecode (
    .ctrlWord  (ctrl_r),
    .reqMaster (reqMaster),
    .reqSlave  (reqSlave),
    .reqChar   (reqChar),
    .reqMulti  (reqMulti),
    .reqNone   (reqNone)
  );

  ssw_frame_delay uDelay (
    .baudCode (line_r[LP_BAUD_LSB +: LP_BAUD_W]),
    .delayUs  (defDelayUs)
  );

  always_comb begin
    startReq = coldStart | warmStart;
    cmdTaken = writeCmd && (state_r == ST_IDLE) && !startReq;
    applyNow = (state_r == ST_WAIT) && !lineBusy && !startReq;
    if (reqMaster) begin
      reqMode = MODE_MASTER;
    end else if (reqChar) begin
      reqMode = MODE_CHAR;
    end else begin
      reqMode = MODE_SLAVE;
    end
  end

  always_comb begin
    state_nxt       = state_r;
    target_nxt      = target_r;
    mode_nxt        = mode_r;
    ctrl_nxt        = ctrl_r;
    line_nxt        = line_r;
    fd_nxt          = fd_r;
    ato_nxt         = ato_r;
    retry_nxt       = retry_r;
    endDet_nxt      = endDet_r;
    sil_nxt         = sil_r;
    endChar_nxt     = endChar_r;
    slave_nxt       = slave_r;
    initSlave_nxt   = initSlave_r;
    initIsSlave_nxt = initIsSlave_r;
    done_nxt        = 1'b0;
    err_nxt         = 1'b0;
    report_nxt      = report_r;
    // Storing the word alone does nothing until the write command
    if (ctrlWrEn) begin
      ctrl_nxt = ctrlWrData;
    end
    if (startReq) begin
      // Restore setup; pending switch is dropped
      state_nxt   = ST_IDLE;
      mode_nxt    = useAppCfg ? appMode : MODE_SLAVE;
      line_nxt    = useAppCfg ? appLineParams : DEF_LINE;
      fd_nxt      = FD_FAST_US;
      slave_nxt   = useAppCfg ? appSlaveNum : DEF_SLAVE_NUM;
      ato_nxt     = ANSWER_TIMEOUT_MS;
      retry_nxt   = IS_EXPANSION ? RETRY_EXP : RETRY_CPU;
      endDet_nxt  = IS_EXPANSION ? END_ON_CHAR : END_SILENCE;
      sil_nxt     = SILENCE_MS;
      endChar_nxt = END_CHAR;
      initSlave_nxt   = useAppCfg ? appSlaveNum : DEF_SLAVE_NUM;
      initIsSlave_nxt = useAppCfg ? (appMode == MODE_SLAVE) : 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (writeCmd) begin
            if (IS_EXPANSION && reqMulti) begin
              err_nxt = 1'b1;
            end else if (!IS_EXPANSION && !initIsSlave_r) begin
              err_nxt = 1'b1;
            end else if (reqNone) begin
              done_nxt = 1'b1;
            end else begin
              // Request is sampled once here; later edits to the word cannot disturb it
              target_nxt = reqMode;
              state_nxt  = ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Switching mid-frame would corrupt the frame on the line
          if (!lineBusy) begin
            state_nxt = ST_IDLE;
            mode_nxt  = target_r;
            done_nxt  = 1'b1;
            // line_r is left alone in every branch
            case (target_r)
              MODE_MASTER: begin
                fd_nxt    = defDelayUs;
                ato_nxt   = ANSWER_TIMEOUT_MS;
                retry_nxt = IS_EXPANSION ? RETRY_EXP : RETRY_CPU;
              end
              MODE_CHAR: begin
                if (IS_EXPANSION) begin
                  endDet_nxt  = END_ON_CHAR;
                  endChar_nxt = END_CHAR;
                end else begin
                  endDet_nxt = END_SILENCE;
                  sil_nxt    = SILENCE_MS;
                end
              end
              MODE_SLAVE: begin
                if (IS_EXPANSION) begin
                  slave_nxt = nvSlaveValid ? nvSlaveNum : DEF_SLAVE_NUM;
                end else begin
                  slave_nxt = initSlave_r;
                end
              end
              default: begin
                mode_nxt = mode_r;
              end
            endcase
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    // Only the master role issues requests that a second master can spoil
    if (done_nxt) begin
      report_nxt = REPORT_OK;
    end else if (reqLost && mode_r == MODE_MASTER) begin
      report_nxt = slaveAbsent ? REPORT_SLAVE_ABSENT : REPORT_NOT_PROCESSED;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r       <= ST_IDLE;
      target_r      <= MODE_SLAVE;
      mode_r        <= MODE_SLAVE;
      ctrl_r        <= CTRL_RESET;
      line_r        <= DEF_LINE;
      fd_r          <= FD_FAST_US;
      ato_r         <= ANSWER_TIMEOUT_MS;
      retry_r       <= IS_EXPANSION ? RETRY_EXP : RETRY_CPU;
      endDet_r      <= IS_EXPANSION ? END_ON_CHAR : END_SILENCE;
      sil_r         <= SILENCE_MS;
      endChar_r     <= END_CHAR;
      slave_r       <= DEF_SLAVE_NUM;
      initSlave_r   <= DEF_SLAVE_NUM;
      initIsSlave_r <= 1'b1;
      done_r        <= 1'b0;
      err_r         <= 1'b0;
      report_r      <= REPORT_OK;
    end else begin
      state_r       <= state_nxt;
      target_r      <= target_nxt;
      mode_r        <= mode_nxt;
      ctrl_r        <= ctrl_nxt;
      line_r        <= line_nxt;
      fd_r          <= fd_nxt;
      ato_r         <= ato_nxt;
      retry_r       <= retry_nxt;
      endDet_r      <= endDet_nxt;
      sil_r         <= sil_nxt;
      endChar_r     <= endChar_nxt;
      slave_r       <= slave_nxt;
      initSlave_r   <= initSlave_nxt;
      initIsSlave_r <= initIsSlave_nxt;
      done_r        <= done_nxt;
      err_r         <= err_nxt;
      report_r      <= report_nxt;
    end
  end

  assign ctrlRdData      = ctrl_r;
  assign mode            = mode_r;
  assign lineParams      = line_r;
  assign frameDelayUs    = fd_r;
  assign answerTimeoutMs = ato_r;
  assign retryCount      = retry_r;
  assign endDetect       = endDet_r;
  assign silenceMs       = sil_r;
  assign endChar         = endChar_r;
  assign slaveNum        = slave_r;
  assign cmdDone         = done_r;
  assign cmdError        = err_r;
  assign switchPending   = (state_r == ST_WAIT);
  assign exchReport      = report_r;

  property p_no_cmd_no_switch;
    @(posedge clk) disable iff (srst) (state_r == ST_IDLE && !startReq) |=> $stable(mode_r);
  endproperty
  a_no_cmd_no_switch: assert property (p_no_cmd_no_switch) else $error("Mode moved without command");

  property p_multi_error;
    @(posedge clk) disable iff (srst) (IS_EXPANSION && cmdTaken && reqMulti) |=> err_r && state_r == ST_IDLE;
  endproperty
  a_multi_error: assert property (p_multi_error) else $error("Several request bits not flagged");

  property p_cpu_refuse;
    @(posedge clk) disable iff (srst)
      (!IS_EXPANSION && cmdTaken && !initIsSlave_r) |=> err_r ##1 (state_r == ST_IDLE);
  endproperty
  a_cpu_refuse: assert property (p_cpu_refuse) else $error("Switch allowed on non-slave port");

  property p_line_kept;
    @(posedge clk) disable iff (srst) applyNow |=> $stable(line_r) && done_r;
  endproperty
  a_line_kept: assert property (p_line_kept) else $error("Line parameters changed by switch");

  property p_master_values;
    @(posedge clk) disable iff (srst) (applyNow && target_r == MODE_MASTER) |=>
      mode_r == MODE_MASTER && ato_r == 16'h0BB8 && retry_r == (IS_EXPANSION ? 4'h0 : 4'h3)
      && fd_r == $past(defDelayUs);
  endproperty
  a_master_values: assert property (p_master_values) else $error("Master values wrong");

  property p_char_values;
    @(posedge clk) disable iff (srst) (applyNow && target_r == MODE_CHAR) |=>
      (IS_EXPANSION ? (endDet_r == END_ON_CHAR && endChar_r == 8'h0D)
                    : (endDet_r == END_SILENCE && sil_r == 16'h03E8));
  endproperty
  a_char_values: assert property (p_char_values) else $error("Character end detection wrong");

  property p_slave_number;
    @(posedge clk) disable iff (srst) (IS_EXPANSION && applyNow && target_r == MODE_SLAVE) |=>
      slave_r == ($past(nvSlaveValid) ? $past(nvSlaveNum) : 8'hF8);
  endproperty
  a_slave_number: assert property (p_slave_number) else $error("Slave number not reloaded");

  property p_wait_busy;
    @(posedge clk) disable iff (srst) (state_r == ST_WAIT && lineBusy && !startReq) |=>
      $stable(mode_r) && state_r == ST_WAIT;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("Switch applied during a frame");

  property p_start_restore;
    @(posedge clk) disable iff (srst) (startReq && !useAppCfg) |=>
      mode_r == MODE_SLAVE && line_r == DEF_LINE && slave_r == 8'hF8 ##1 !err_r;
  endproperty
  a_start_restore: assert property (p_start_restore) else $error("Start did not restore defaults");

  property p_report;
    @(posedge clk) disable iff (srst) (reqLost && mode_r == MODE_MASTER && !done_nxt) |=>
      exchReport == ($past(slaveAbsent) ? 16'h0DFF : 16'h0100);
  endproperty
  a_report: assert property (p_report) else $error("Lost request not reported");

endmodule // ssw_switcher

// ==== logic/ssw_pkg.sv ====
// Constants and types shared by the protocol switcher
package ssw_pkg;

  // Control word layout
  localparam int unsigned CTRL_BIT_MASTER = 12;
  localparam int unsigned CTRL_BIT_SLAVE  = 13;
  localparam int unsigned CTRL_BIT_CHAR   = 14;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;

  // Master role values
  localparam logic [15:0] ANSWER_TIMEOUT_MS = 16'h0BB8;
  localparam logic [3:0]  RETRY_CPU         = 4'h3;
  localparam logic [3:0]  RETRY_EXP         = 4'h0;

  // Character role values
  localparam logic [15:0] SILENCE_MS = 16'h03E8;
  localparam logic [7:0]  END_CHAR   = 8'h0D;

  // Slave role values
  localparam logic [7:0] DEF_SLAVE_NUM = 8'hF8;

  // Line parameter word: [2:0] baud code, [3] RTU, [5:4] parity, [6] two stop, [7] flow, [8] RS485
  localparam int unsigned LP_BAUD_LSB = 0;
  localparam int unsigned LP_BAUD_W   = 3;
  localparam logic [2:0]  BAUD_1200   = 3'h0;
  localparam logic [2:0]  BAUD_2400   = 3'h1;
  localparam logic [2:0]  BAUD_4800   = 3'h2;
  localparam logic [2:0]  BAUD_9600   = 3'h3;
  localparam logic [2:0]  BAUD_19200  = 3'h4;
  // 19200 baud, RTU, even parity, one stop, no flow; channel 0 RS232, channel 1 RS485
  localparam logic [15:0] DEF_LINE_CH0 = 16'h001C;
  localparam logic [15:0] DEF_LINE_CH1 = 16'h011C;

  // Inter-frame delay defaults in microseconds, 3.5 characters below 19200 baud
  localparam logic [15:0] FD_1200_US  = 16'h7D53;
  localparam logic [15:0] FD_2400_US  = 16'h3EAA;
  localparam logic [15:0] FD_4800_US  = 16'h1F55;
  localparam logic [15:0] FD_9600_US  = 16'h0FAA;
  localparam logic [15:0] FD_FAST_US  = 16'h06D6;

  // Exchange reports
  localparam logic [15:0] REPORT_OK            = 16'h0000;
  localparam logic [15:0] REPORT_NOT_PROCESSED = 16'h0100;
  localparam logic [15:0] REPORT_SLAVE_ABSENT  = 16'h0DFF;

  typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_CHAR} ssw_mode_t;
  typedef enum logic {END_SILENCE, END_ON_CHAR} ssw_end_t;

endpackage

// ==== logic/ssw_req_decode.sv ====
// Decoder of the protocol request bits of the control word
`timescale 1ns/10ps
module ssw_req_decode (
  // Control word
  input  wire logic [15:0] ctrlWord,
  // Decoded request
  output logic             reqMaster,
  output logic             reqSlave,
  output logic             reqChar,
  output logic             reqMulti,
  output logic             reqNone
);
  import ssw_pkg::*;

  logic [1:0] cnt;

  always_comb begin
    reqMaster = ctrlWord[CTRL_BIT_MASTER];
    reqSlave  = ctrlWord[CTRL_BIT_SLAVE];
    reqChar   = ctrlWord[CTRL_BIT_CHAR];
    cnt       = 2'({1'b0, reqMaster}) + 2'({1'b0, reqSlave}) + 2'({1'b0, reqChar});
    reqMulti  = cnt > 2'h1;
    reqNone   = cnt == 2'h0;
  end
endmodule // ssw_req_decode

// ==== logic/ssw_frame_delay.sv ====
// Default inter-frame delay selected by the line speed
`timescale 1ns/10ps
module ssw_frame_delay (
  // Line speed
  input  wire logic [2:0]  baudCode,
  // Default delay
  output logic      [15:0] delayUs
);
  import ssw_pkg::*;

  always_comb begin
    case (baudCode)
      BAUD_1200: delayUs = FD_1200_US;
      BAUD_2400: delayUs = FD_2400_US;
      BAUD_4800: delayUs = FD_4800_US;
      BAUD_9600: delayUs = FD_9600_US;
      default:   delayUs = FD_FAST_US;
    endcase
  end
endmodule // ssw_frame_delay

// ==== verification/ssw_line_model.sv ====
// Line engine and stored slave number model facing the switcher
`timescale 1ns/10ps
module ssw_line_model (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // Bench controls
  input  wire logic               frameGo,
  input  wire logic               collide,
  input  wire logic               nvPresent,
  input  wire ssw_pkg::ssw_mode_t mode,
  // Line engine status
  output logic                    lineBusy,
  output logic                    reqLost,
  output logic                    slaveAbsent,
  // Stored slave number
  output logic                    nvSlaveValid,
  output logic [7:0]              nvSlaveNum
);
  import ssw_pkg::*;
  logic [3:0] busyCnt;
  logic [7:0] junk;
  assign lineBusy     = (busyCnt != 4'h0);
  assign nvSlaveValid = nvPresent;
  // Moving pattern when nothing is stored, so a stale number cannot pass
  assign nvSlaveNum   = nvPresent ? 8'h2A : junk;
  always_ff @(posedge clk) begin
    if (srst) begin
      busyCnt     <= 4'h0;
      reqLost     <= 1'b0;
      slaveAbsent <= 1'b0;
      junk        <= 8'h00;
    end else begin
      junk    <= junk + 8'h35;
      busyCnt <= frameGo ? 4'hA : (lineBusy ? busyCnt - 4'h1 : 4'h0);
      // Two masters talking at once lose the request; the cause alternates
      reqLost <= collide && (mode == MODE_MASTER);
      if (collide && (mode == MODE_MASTER)) begin
        slaveAbsent <= ~slaveAbsent;
      end
    end
  end
endmodule // ssw_line_model

// ==== verification/ssw_switcher_bench.sv ====
// Bench of the switcher, expansion port at index 0 and processor port at index 1
`timescale 1ns/10ps
module ssw_switcher_bench;
  import ssw_pkg::*;
  typedef struct {logic [15:0] word; ssw_mode_t m0; ssw_mode_t m1; logic e0; logic e1;} ssw_row_t;
  logic        clk, srst, ctrlWrEn, writeCmd, coldStart, warmStart, useAppCfg, nvPresent, frameGo, collide, clrSeen;
  logic [15:0] ctrlWrData, appLineParams, lineExp;
  logic [7:0]  appSlaveNum, nvSlaveNum;
  ssw_mode_t   appMode;
  logic        lineBusy, reqLost, slaveAbsent, nvSlaveValid;
  ssw_mode_t   mode [2];
  ssw_end_t    endDetect [2];
  logic [15:0] ctrlRdData [2], lineParams [2], frameDelayUs [2], answerTimeoutMs [2], silenceMs [2], exchReport [2];
  logic [3:0]  retryCount [2];
  logic [7:0]  endChar [2], slaveNum [2], slaveExp [2];
  logic        cmdDone [2], cmdError [2], switchPending [2];
  logic [1:0]  sawDone, sawErr;
  int          fails, num_checks;
  ssw_row_t    rows [6];
  for (genvar g = 0; g < 2; g++) begin : g_port
    ssw_switcher #(.IS_EXPANSION(g == 0), .CHANNEL(1'h0)) dut (
      .clk(clk), .srst(srst), .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData), .writeCmd(writeCmd),
      .ctrlRdData(ctrlRdData[g]), .coldStart(coldStart), .warmStart(warmStart), .useAppCfg(useAppCfg),
      .appMode(appMode), .appLineParams(appLineParams), .appSlaveNum(appSlaveNum), .nvSlaveValid(nvSlaveValid),
      .nvSlaveNum(nvSlaveNum), .lineBusy(lineBusy), .reqLost(reqLost), .slaveAbsent(slaveAbsent),
      .mode(mode[g]), .lineParams(lineParams[g]), .frameDelayUs(frameDelayUs[g]),
      .answerTimeoutMs(answerTimeoutMs[g]), .retryCount(retryCount[g]), .endDetect(endDetect[g]),
      .silenceMs(silenceMs[g]), .endChar(endChar[g]), .slaveNum(slaveNum[g]), .cmdDone(cmdDone[g]),
      .cmdError(cmdError[g]), .switchPending(switchPending[g]), .exchReport(exchReport[g]));
  end
  ssw_line_model line (.clk(clk), .srst(srst), .frameGo(frameGo), .collide(collide), .nvPresent(nvPresent),
    .mode(mode[0]), .lineBusy(lineBusy), .reqLost(reqLost), .slaveAbsent(slaveAbsent),
    .nvSlaveValid(nvSlaveValid), .nvSlaveNum(nvSlaveNum));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses last one cycle, so they are caught here rather than polled
  always_ff @(posedge clk) begin
    sawDone <= clrSeen ? 2'b00 : (sawDone | {cmdDone[1], cmdDone[0]});
    sawErr  <= clrSeen ? 2'b00 : (sawErr | {cmdError[1], cmdError[0]});
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One-hot select: frameGo, collide, warmStart, coldStart
  task automatic pulse(input logic [3:0] sel);
    @(posedge clk);
    {frameGo, collide, warmStart, coldStart} <= sel;
    @(posedge clk);
    {frameGo, collide, warmStart, coldStart} <= 4'h0;
  endtask
  task automatic sendCmd(input logic [15:0] w);
    @(posedge clk);
    ctrlWrEn   <= 1'b1;
    ctrlWrData <= w;
    @(posedge clk);
    ctrlWrEn <= 1'b0;
    writeCmd <= 1'b1;
    clrSeen  <= 1'b1;
    @(posedge clk);
    writeCmd <= 1'b0;
    clrSeen  <= 1'b0;
  endtask
  task automatic waitDone(input logic e0, input logic e1);
    int k;
    // Flags are cleared by clrSeen while the command is written, so the last command's flags cannot end the wait
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if ((sawDone | sawErr) == 2'b11) break;
    end
    if (k == 40) begin
      fails++;
      give_verdict();
    end else begin
      chk("error exp", 16'(sawErr[0]), 16'(e0));
      chk("error cpu", 16'(sawErr[1]), 16'(e1));
    end
  endtask
  task automatic checkCfg(input int i, input ssw_mode_t m, input logic [15:0] fd);
    chk("mode", 16'(mode[i]), 16'(m));
    chk("line", lineParams[i], lineExp);
    case (m)
      MODE_MASTER: begin
        chk("delay", frameDelayUs[i], fd);
        chk("timeout", answerTimeoutMs[i], ANSWER_TIMEOUT_MS);
        chk("retry", 16'(retryCount[i]), (i == 0) ? 16'(RETRY_EXP) : 16'(RETRY_CPU));
      end
      MODE_CHAR: begin
        chk("end", 16'(endDetect[i]), (i == 0) ? 16'(END_ON_CHAR) : 16'(END_SILENCE));
        chk("stop", (i == 0) ? 16'(endChar[i]) : silenceMs[i], (i == 0) ? 16'(END_CHAR) : SILENCE_MS);
      end
      default: chk("slave", 16'(slaveNum[i]), 16'(slaveExp[i]));
    endcase
  endtask
  initial begin
    // Row 3 sets two bits on purpose; the processor port resolves it to master
    rows = '{'{16'h4000, MODE_CHAR, MODE_CHAR, 0, 0}, '{16'h1000, MODE_MASTER, MODE_MASTER, 0, 0},
             '{16'h2000, MODE_SLAVE, MODE_SLAVE, 0, 0}, '{16'h3000, MODE_SLAVE, MODE_MASTER, 1, 0},
             '{16'h0000, MODE_SLAVE, MODE_MASTER, 0, 0}, '{16'h2000, MODE_SLAVE, MODE_SLAVE, 0, 0}};
    {srst, clrSeen, nvPresent} = 3'h7;
    {ctrlWrEn, writeCmd, coldStart, warmStart, useAppCfg, frameGo, collide} = 7'h00;
    ctrlWrData    = 16'h0000;
    appLineParams = 16'h0000;
    appSlaveNum   = 8'h00;
    appMode       = MODE_SLAVE;
    fails         = 0;
    num_checks    = 0;
    lineExp       = DEF_LINE_CH0;
    slaveExp      = '{8'hF8, 8'hF8};
    repeat (4) @(posedge clk);
    srst    <= 1'b0;
    clrSeen <= 1'b0;
    #1;
    for (int i = 0; i < 2; i++) begin
      checkCfg(i, MODE_SLAVE, FD_FAST_US);
      chk("delay", frameDelayUs[i], FD_FAST_US);
      chk("rd", ctrlRdData[i], CTRL_RESET);
    end
    // Word alone must not switch anything
    @(posedge clk);
    ctrlWrEn   <= 1'b1;
    ctrlWrData <= 16'h1000;
    @(posedge clk);
    ctrlWrEn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("rd", ctrlRdData[0], 16'h1000);
    chk("mode", 16'(mode[0]), 16'(MODE_SLAVE));
    slaveExp[0] = 8'h2A;
    foreach (rows[r]) begin
      sendCmd(rows[r].word);
      waitDone(rows[r].e0, rows[r].e1);
      checkCfg(0, rows[r].m0, FD_FAST_US);
      checkCfg(1, rows[r].m1, FD_FAST_US);
    end
    // Switch held back while a frame is on the line
    pulse(4'h8);
    sendCmd(16'h4000);
    #1;
    chk("pending", 16'(switchPending[0]), 16'h0001);
    chk("mode", 16'(mode[0]), 16'(MODE_SLAVE));
    waitDone(1'b0, 1'b0);
    checkCfg(0, MODE_CHAR, FD_FAST_US);
    sendCmd(16'h1000);
    waitDone(1'b0, 1'b0);
    checkCfg(0, MODE_MASTER, FD_FAST_US);
    for (int n = 0; n < 2; n++) begin
      pulse(4'h4);
      repeat (3) @(posedge clk);
      #1;
      chk("report", exchReport[0], (n == 0) ? REPORT_SLAVE_ABSENT : REPORT_NOT_PROCESSED);
      chk("report", exchReport[1], (n == 0) ? REPORT_SLAVE_ABSENT : REPORT_NOT_PROCESSED);
    end
    @(posedge clk);
    nvPresent <= 1'b0;
    slaveExp[0] = DEF_SLAVE_NUM;
    sendCmd(16'h2000);
    waitDone(1'b0, 1'b0);
    checkCfg(0, MODE_SLAVE, FD_FAST_US);
    // Application setup at 9600 baud starting as master
    @(posedge clk);
    useAppCfg     <= 1'b1;
    appMode       <= MODE_MASTER;
    appLineParams <= 16'h001B;
    appSlaveNum   <= 8'h11;
    pulse(4'h2);
    @(posedge clk);
    #1;
    lineExp = 16'h001B;
    for (int i = 0; i < 2; i++) checkCfg(i, MODE_MASTER, FD_FAST_US);
    chk("slave", 16'(slaveNum[0]), 16'h0011);
    sendCmd(16'h4000);
    waitDone(1'b0, 1'b1);
    sendCmd(16'h1000);
    waitDone(1'b0, 1'b1);
    checkCfg(0, MODE_MASTER, FD_9600_US);
    checkCfg(1, MODE_MASTER, FD_FAST_US);
    @(posedge clk);
    useAppCfg <= 1'b0;
    pulse(4'h1);
    @(posedge clk);
    #1;
    lineExp  = DEF_LINE_CH0;
    slaveExp = '{8'hF8, 8'hF8};
    for (int i = 0; i < 2; i++) checkCfg(i, MODE_SLAVE, FD_FAST_US);
    give_verdict();
  end
endmodule // ssw_switcher_bench
